// ---- umh_pkg.sv ----
`default_nettype none
package umh_pkg;
    // register byte offsets
    localparam logic [11:0] UMH_OFF_IER = 12'h004;
    localparam logic [11:0] UMH_OFF_MCR = 12'h010;
    localparam logic [11:0] UMH_OFF_MSR = 12'h014;

    // modem_control fields
    localparam int UMH_MCR_RTS_CTRL_BIT = 1;
    localparam int UMH_MCR_RTS_POL_BIT  = 9;
    localparam int UMH_MCR_RTS_LVL_BIT  = 13;

    // modem_status fields
    localparam int UMH_MSR_CHG_BIT      = 0;
    localparam int UMH_MSR_CTS_LVL_BIT  = 4;
    localparam int UMH_MSR_CTS_POL_BIT  = 8;

    // interrupt_enable_register fields
    localparam int UMH_IER_MODEM_BIT    = 3;

    // byte lanes holding the writable fields
    localparam int UMH_LANE_LOW         = 0;
    localparam int UMH_LANE_HIGH        = 1;

    // reset words
    localparam logic [31:0] UMH_MCR_RESET = 32'h0000_0200;
    localparam logic [31:0] UMH_MSR_RESET = 32'h0000_0110;
    localparam logic [31:0] UMH_IER_RESET = 32'h0000_0000;

    // synchroniser depth in flip-flops
    localparam int UMH_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ---- umh_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module umh_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    import umh_pkg::*;

    logic [UMH_SYNC_STAGES-1:0] chain_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            chain_q <= {UMH_SYNC_STAGES{RESET_VAL}};
        else if (ce)
            chain_q <= {chain_q[UMH_SYNC_STAGES-2:0], d};
    end

    assign q = chain_q[UMH_SYNC_STAGES-1];
endmodule
`default_nettype wire

// ---- umh_top.sv ----
// What this block does
// - modem_control bit 13 reads back the actual request pin level.
// - request_polarity 0 drives pin active high, 1 drives active low.
// - software request bit 0 means active, 1 inactive, through polarity.
// - automatic flow control in normal mode overrides the software bit.
// - rs485 auto direction in rs485 mode overrides the software bit.
// - clear_polarity 0 means input active high, 1 active low.
// - modem_status bit 4 reads the synchronised, held clear level, not the raw pin.
// - clear level follows the pin only when clocked and routed.
// - a clear input change seen while clocked and routed sets the sticky clear_change_flag.
// - flag set with modem_interrupt_enable raises the modem interrupt.
// - writing 1 clears the change flag, writing 0 leaves it.
// - modem_control resets to 0x0000_0200, request active low.
// - modem_status resets to 0x0000_0110, level reads high.
`timescale 1ns/1ps
`default_nettype none
module umh_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pclk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        clear_pin,
    input  wire logic        clear_mux_sel,
    input  wire logic        rs485_mode,
    input  wire logic        auto_rts_enable,
    input  wire logic        auto_rts_active,
    input  wire logic        rs485_auto_direction_enable,
    input  wire logic        rs485_dir_active,
    output logic             request_pin,
    output logic             clear_active,
    output logic             modem_irq
);
    import umh_pkg::*;

    function automatic logic [31:0] umh_bit(input logic v, input int pos);
        umh_bit = 32'(v) << pos;
    endfunction

    // apb phase decode
    logic        access_first;
    logic        access_done;
    logic        sel_mcr;
    logic        sel_msr;
    logic        sel_ier;
    logic        mapped;
    logic        wr_ok;
    logic        wr_low;
    logic        wr_high;
    logic        pready_q;
    logic        pslverr_q;

    assign access_first = psel & penable & ~pready_q;
    assign access_done  = psel & penable & pready_q;
    assign sel_mcr      = (paddr == UMH_OFF_MCR);
    assign sel_msr      = (paddr == UMH_OFF_MSR);
    assign sel_ier      = (paddr == UMH_OFF_IER);
    assign mapped       = sel_mcr | sel_msr | sel_ier;
    assign wr_ok        = access_done & pwrite & ~pslverr_q;
    assign wr_low       = wr_ok & pstrb[UMH_LANE_LOW];
    assign wr_high      = wr_ok & pstrb[UMH_LANE_HIGH];

    // state
    logic [31:0] prdata_q;
    logic        rts_ctrl_q;
    logic        rts_pol_q;
    logic        request_q;
    logic        cts_pol_q;
    logic        cts_lvl_q;
    logic        chg_q;
    logic        ien_q;
    logic        clear_active_q;
    logic        irq_q;

    // next values
    logic        rts_ctrl_d;
    logic        rts_pol_d;
    logic        request_d;
    logic        cts_pol_d;
    logic        cts_lvl_d;
    logic        chg_d;
    logic        ien_d;
    logic        irq_d;
    logic [31:0] prdata_d;

    // control field writes
    assign rts_ctrl_d = (wr_low & sel_mcr) ?
                        pwdata[UMH_MCR_RTS_CTRL_BIT] : rts_ctrl_q;
    assign rts_pol_d  = (wr_high & sel_mcr) ?
                        pwdata[UMH_MCR_RTS_POL_BIT] : rts_pol_q;
    assign cts_pol_d  = (wr_high & sel_msr) ?
                        pwdata[UMH_MSR_CTS_POL_BIT] : cts_pol_q;
    assign ien_d      = (wr_low & sel_ier) ?
                        pwdata[UMH_IER_MODEM_BIT] : ien_q;

    // request path
    logic        auto_flow_on;
    logic        auto_dir_on;
    logic        rts_active;

    assign auto_flow_on = auto_rts_enable & ~rs485_mode;
    assign auto_dir_on  = rs485_auto_direction_enable & rs485_mode;
    assign rts_active   = auto_dir_on  ? rs485_dir_active :
                          auto_flow_on ? auto_rts_active  :
                          ~rts_ctrl_q;
    assign request_d    = rts_pol_q ? ~rts_active : rts_active;

    // clear path
    logic        cts_sync;
    logic        cts_changed;
    logic        chg_clear;

    umh_sync #(
        .RESET_VAL (UMH_MSR_RESET[UMH_MSR_CTS_LVL_BIT])
    ) u_clear_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (pclk_en),
        .d     (clear_pin),
        .q     (cts_sync)
    );

    assign cts_lvl_d   = clear_mux_sel ? cts_sync : cts_lvl_q;
    assign cts_changed = clear_mux_sel & (cts_sync != cts_lvl_q);
    assign chg_clear   = wr_low & sel_msr & pwdata[UMH_MSR_CHG_BIT];
    assign chg_d       = cts_changed | (chg_q & ~chg_clear);
    assign irq_d       = chg_d & ien_d;

    // read words
    logic [31:0] mcr_word;
    logic [31:0] msr_word;
    logic [31:0] ier_word;

    assign mcr_word = umh_bit(rts_ctrl_q, UMH_MCR_RTS_CTRL_BIT)
                    | umh_bit(rts_pol_q, UMH_MCR_RTS_POL_BIT)
                    | umh_bit(request_q, UMH_MCR_RTS_LVL_BIT);
    assign msr_word = umh_bit(chg_q, UMH_MSR_CHG_BIT)
                    | umh_bit(cts_lvl_q, UMH_MSR_CTS_LVL_BIT)
                    | umh_bit(cts_pol_q, UMH_MSR_CTS_POL_BIT);
    assign ier_word = umh_bit(ien_q, UMH_IER_MODEM_BIT);
    assign prdata_d = pwrite  ? 32'h0000_0000 :
                      sel_mcr ? mcr_word :
                      sel_msr ? msr_word :
                      sel_ier ? ier_word : 32'h0000_0000;

    // bus slave, one wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else if (pclk_en)
        begin
            pready_q  <= access_first;
            pslverr_q <= access_first & ~mapped;
            if (access_first)
                prdata_q <= prdata_d;
        end
    end

    // modem control and status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rts_ctrl_q <= UMH_MCR_RESET[UMH_MCR_RTS_CTRL_BIT];
            rts_pol_q  <= UMH_MCR_RESET[UMH_MCR_RTS_POL_BIT];
            request_q  <= UMH_MCR_RESET[UMH_MCR_RTS_LVL_BIT];
            cts_pol_q  <= UMH_MSR_RESET[UMH_MSR_CTS_POL_BIT];
            cts_lvl_q  <= UMH_MSR_RESET[UMH_MSR_CTS_LVL_BIT];
            chg_q      <= UMH_MSR_RESET[UMH_MSR_CHG_BIT];
            ien_q      <= UMH_IER_RESET[UMH_IER_MODEM_BIT];
        end
        else if (pclk_en)
        begin
            rts_ctrl_q <= rts_ctrl_d;
            rts_pol_q  <= rts_pol_d;
            request_q  <= request_d;
            cts_pol_q  <= cts_pol_d;
            cts_lvl_q  <= cts_lvl_d;
            chg_q      <= chg_d;
            ien_q      <= ien_d;
        end
    end

    // outputs towards pin and processor
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clear_active_q <= 1'b0;
            irq_q          <= 1'b0;
        end
        else if (pclk_en)
        begin
            clear_active_q <= cts_lvl_d ^ cts_pol_d;
            irq_q          <= irq_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign request_pin  = request_q;
    assign clear_active = clear_active_q;
    assign modem_irq    = irq_q;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_rts_level_read: assert property (
        (access_first && !pwrite && sel_mcr && pclk_en)
        |=> prdata[UMH_MCR_RTS_LVL_BIT] == $past(request_q))
        else $error("request level readback wrong");

    a_rts_polarity_sw: assert property (
        (pclk_en && !auto_flow_on && !auto_dir_on)
        |=> request_pin == ($past(rts_pol_q) ^ ~$past(rts_ctrl_q)))
        else $error("request pin polarity wrong");

    a_rts_sw_write: assert property (
        (wr_ok && pstrb == 4'hf && sel_mcr && pclk_en
         && !pwdata[UMH_MCR_RTS_CTRL_BIT] && pwdata[UMH_MCR_RTS_POL_BIT])
        ##1 (pclk_en && !auto_flow_on && !auto_dir_on)
        |=> !request_pin)
        else $error("software request did not drive pin low");

    a_rts_auto_flow: assert property (
        (pclk_en && auto_flow_on && !auto_dir_on)
        |=> request_pin == ($past(rts_pol_q) ^ $past(auto_rts_active)))
        else $error("auto flow did not own request pin");

    a_rts_auto_dir: assert property (
        (pclk_en && auto_dir_on)
        |=> request_pin == ($past(rts_pol_q) ^ $past(rs485_dir_active)))
        else $error("auto direction did not own request pin");

    a_cts_active_sense: assert property (
        clear_active == (cts_lvl_q ^ cts_pol_q))
        else $error("clear active sense wrong");

    a_cts_level_follow: assert property (
        (pclk_en && clear_mux_sel && $stable(clear_pin)) [*4]
        |-> cts_lvl_q == clear_pin)
        else $error("clear level does not follow pin");

    a_cts_level_hold: assert property (
        (pclk_en && !clear_mux_sel) |=> $stable(cts_lvl_q))
        else $error("clear level moved while not routed");

    a_chg_flag_set: assert property (
        (pclk_en && cts_changed) |=> chg_q && modem_irq == ien_q)
        else $error("change flag not set on clear change");

    a_irq_from_flag: assert property (
        modem_irq == (chg_q && ien_q))
        else $error("modem interrupt disagrees with flag and enable");

    a_chg_flag_clear: assert property (
        (pclk_en && chg_clear && !cts_changed) |=> !chg_q)
        else $error("change flag not cleared by write of one");

    a_chg_flag_keep: assert property (
        (pclk_en && chg_q && wr_low && sel_msr
         && !pwdata[UMH_MSR_CHG_BIT]) |=> chg_q)
        else $error("change flag lost on write of zero");

    a_reset_values: assert property (
        $rose(presetn) |-> rts_pol_q && !rts_ctrl_q && !request_q
        && cts_pol_q && cts_lvl_q && !chg_q)
        else $error("reset values wrong");

    a_sync_latency: assert property (
        (presetn && pclk_en) [*2] ##1 (presetn && pclk_en && clear_mux_sel)
        |=> cts_lvl_q == $past(clear_pin, 3))
        else $error("clear pin reached level without synchroniser");

    a_msr_level_read: assert property (
        (access_first && !pwrite && sel_msr && pclk_en)
        |=> prdata[UMH_MSR_CTS_LVL_BIT] == $past(cts_lvl_q))
        else $error("clear level readback wrong");

    a_irq_drop_clear: assert property (
        (pclk_en && chg_clear && !cts_changed) |=> !modem_irq)
        else $error("modem interrupt stayed after flag clear");

    a_reset_status: assert property (
        $rose(presetn) |-> !ien_q && !chg_q && !modem_irq && !clear_active)
        else $error("status side reset values wrong");

    a_slverr_unmapped: assert property (
        (pclk_en && access_first && !mapped)
        |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_bus_one_wait: assert property (
        (pclk_en && access_first && mapped) |=> pready && !pslverr)
        else $error("bus answer not after one wait state");
endmodule
`default_nettype wire

// ---- umh_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
// remote peer driving the clear line, prompt or slow
module umh_peer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       level_cmd,
    input  wire logic [3:0] lag,
    output logic            clear_pin
);
    logic [3:0] wait_q;
    logic       pin_q;

    assign clear_pin = pin_q;

    // idle high: inactive for the active-low default
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q  <= 1'b1;
            wait_q <= 4'h0;
        end
        else if (level_cmd == pin_q)
            wait_q <= 4'h0;
        else if (wait_q >= lag)
        begin
            pin_q  <= level_cmd;
            wait_q <= 4'h0;
        end
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule
`default_nettype wire

// ---- umh_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module umh_top_tb;
    import umh_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        mux_sel = 1'b1;
    logic        mode = 1'b0;
    logic        aen = 1'b0;
    logic        aact = 1'b0;
    logic        den = 1'b0;
    logic        dact = 1'b0;
    logic        peer_level = 1'b1;
    logic [3:0]  peer_lag = 4'h0;
    logic        ce = 1'b1;
    logic [3:0]  strb = 4'hf;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         request_pin;
    wire         clear_active;
    wire         modem_irq;
    wire         clear_pin;
    int          err_total = 0;
    int          checks_done = 0;
    logic [31:0] rd;
    logic        er;
    // {ctrl, pol, mode, aen, aact, den, dact, expected pin}
    logic [7:0]  rows [10] = '{8'h01, 8'h80, 8'h40, 8'hc1, 8'h99,
                               8'h10, 8'he6, 8'h24, 8'h31, 8'h86};

    always #10 pclk = ~pclk;

    umh_top umh_top_i (.pclk(pclk), .presetn(presetn), .pclk_en(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clear_pin(clear_pin), .clear_mux_sel(mux_sel),
        .rs485_mode(mode), .auto_rts_enable(aen), .auto_rts_active(aact),
        .rs485_auto_direction_enable(den), .rs485_dir_active(dact),
        .request_pin(request_pin), .clear_active(clear_active),
        .modem_irq(modem_irq));

    umh_peer umh_peer_i (.pclk(pclk), .presetn(presetn),
        .level_cmd(peer_level), .lag(peer_lag), .clear_pin(clear_pin));

    task automatic chk_bit(input logic got, input logic exp,
                           input string msg);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string msg);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s %h", $time, msg, got);
        end
    endtask

    // one apb transfer, waits for pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk_bit(1'b0, 1'b1, "no pready");
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task give_verdict;
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        give_verdict();
    end

    initial
    begin
        repeat (19) @(posedge pclk);
        chk_bit(request_pin, 1'b0, "pin in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, UMH_OFF_MCR, 32'h0);
        chk_word(rd, 32'h0000_0200, "control reset");
        apb(1'b0, UMH_OFF_MSR, 32'h0);
        chk_word(rd, 32'h0000_0110, "status reset");
        foreach (rows[i])
        begin
            mode <= rows[i][5];
            aen  <= rows[i][4];
            aact <= rows[i][3];
            den  <= rows[i][2];
            dact <= rows[i][1];
            apb(1'b1, UMH_OFF_MCR, {18'h0, 1'b1, 3'h0, rows[i][6], 7'h0,
                rows[i][7], 1'b0});
            repeat (3) @(posedge pclk);
            chk_bit(request_pin, rows[i][0], "request pin");
            apb(1'b0, UMH_OFF_MCR, 32'h0);
            chk_word(rd, {18'h0, rows[i][0], 3'h0, rows[i][6], 7'h0,
                rows[i][7], 1'b0}, "control readback");
        end
        // slow peer lowers the clear line, interrupt masked
        peer_lag   <= 4'h5;
        peer_level <= 1'b0;
        repeat (16) @(posedge pclk);
        chk_bit(modem_irq, 1'b0, "masked irq");
        chk_bit(clear_active, 1'b1, "active low clear");
        apb(1'b0, UMH_OFF_MSR, 32'h0);
        chk_word(rd, 32'h0000_0101, "status after fall");
        apb(1'b1, UMH_OFF_IER, 32'h8);
        repeat (2) @(posedge pclk);
        chk_bit(modem_irq, 1'b1, "irq enabled");
        apb(1'b1, UMH_OFF_MSR, 32'h100);
        apb(1'b0, UMH_OFF_MSR, 32'h0);
        chk_word(rd, 32'h0000_0101, "flag kept on zero");
        apb(1'b1, UMH_OFF_MSR, 32'h101);
        repeat (2) @(posedge pclk);
        chk_bit(modem_irq, 1'b0, "irq cleared");
        apb(1'b0, UMH_OFF_MSR, 32'h0);
        chk_word(rd, 32'h0000_0100, "flag cleared");
        apb(1'b1, UMH_OFF_MSR, 32'h0);
        repeat (3) @(posedge pclk);
        chk_bit(clear_active, 1'b0, "active high clear");
        // pin not routed: level holds, no change seen
        mux_sel    <= 1'b0;
        peer_lag   <= 4'h0;
        peer_level <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, UMH_OFF_MSR, 32'h0);
        chk_word(rd, 32'h0000_0000, "unrouted status");
        mux_sel <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, UMH_OFF_MSR, 32'h0);
        chk_word(rd, 32'h0000_0011, "routed status");
        chk_bit(modem_irq, 1'b1, "irq on rise");
        chk_bit(clear_active, 1'b1, "high level active");
        // clock enable low freezes the clear path
        apb(1'b1, UMH_OFF_MSR, 32'h1);
        ce         <= 1'b0;
        peer_level <= 1'b0;
        repeat (8) @(posedge pclk);
        chk_bit(clear_active, 1'b1, "frozen clear");
        chk_bit(modem_irq, 1'b0, "frozen irq");
        ce <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_bit(clear_active, 1'b0, "thawed clear");
        chk_bit(modem_irq, 1'b1, "thawed irq");
        // lane one only: control bit keeps its value
        strb <= 4'h2;
        apb(1'b1, UMH_OFF_MCR, 32'h0);
        strb <= 4'hf;
        apb(1'b0, UMH_OFF_MCR, 32'h0);
        chk_word(rd, 32'h0000_0002, "lane one only");
        // reset in mid run
        peer_level <= 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, UMH_OFF_MCR, 32'h0);
        chk_word(rd, 32'h0000_0200, "control after reset");
        apb(1'b0, UMH_OFF_MSR, 32'h0);
        chk_word(rd, 32'h0000_0110, "status after reset");
        chk_bit(modem_irq, 1'b0, "irq after reset");
        apb(1'b0, 12'h020, 32'h0);
        chk_word(rd, 32'h0, "unmapped data");
        chk_bit(er, 1'b1, "unmapped error");
        give_verdict();
    end
endmodule
`default_nettype wire
